//--- negate_alu_pkg.sv
/*
 * Shared constants, types and the register map of the negate execute datapath.
 * Assumes a single core clock; the decoder fills one request struct per issued instruction.
 */
package negate_alu_pkg;

    // Widths.
    localparam int DW    = 32;
    localparam int XW    = 40;
    localparam int AW    = 24;
    localparam int BW    = 8;
    localparam int MUL_W = 24;
    localparam int NXR   = 8;

    // Flag bit positions and width of the flags register, and the saturate bit of the control register.
    localparam int FLAG_CARRY              = 0;
    localparam int FLAG_OVERFLOW           = 1;
    localparam int FLAG_ZERO               = 2;
    localparam int FLAG_NEGATIVE           = 3;
    localparam int FLAG_UNDERFLOW          = 4;
    localparam int FLAG_LATCHED_OVERFLOW   = 5;
    localparam int FLAG_LATCHED_UNDERFLOW  = 6;
    localparam int FLAG_W                  = 7;
    localparam int CTRL_OVERFLOW_SATURATE  = 0;

    // Register offsets and reset values.
    localparam logic [BW-1:0]     OFS_CTRL   = 8'h00;
    localparam logic [BW-1:0]     OFS_FLAGS  = 8'h04;
    localparam logic [BW-1:0]     OFS_XLO    = 8'h20;
    localparam logic [BW-1:0]     OFS_XHI    = 8'h40;
    localparam logic [FLAG_W-1:0] FLAGS_RST  = 7'h00;
    localparam logic              CTRL_RST   = 1'b0;
    localparam logic [XW-1:0]     XREG_RST   = 40'h00_0000_0000;

    // Numeric limits.
    localparam logic [DW-1:0] INT_MAX      = 32'h7fff_ffff;
    localparam logic [DW-1:0] INT_MIN      = 32'h8000_0000;
    localparam logic [7:0]    EXP_ZERO     = 8'h80;
    localparam logic [7:0]    EXP_MAX      = 8'h7f;
    localparam logic [7:0]    EXP_MIN      = 8'h81;
    localparam logic [DW-1:0] MANT_NEG_TWO = 32'h8000_0000;
    localparam logic [7:0]    PAR_DISP_MAX = 8'h01;
    localparam logic [4:0]    EXT_LIMIT    = 5'h08;

    typedef enum logic [1:0] {
        OP_MPY_SUB = 2'b00,
        OP_INT_NEGATE_WITH_BORROW    = 2'b01,
        OP_FLOAT_NEGATE    = 2'b10,
        OP_FLOAT_NEGATE_ST = 2'b11
    } op_e;

    typedef enum logic [1:0] {
        MODE_REG = 2'b00,
        MODE_DIR = 2'b01,
        MODE_IND = 2'b10,
        MODE_IMM = 2'b11
    } src_mode_e;

    typedef struct packed {
        logic          is_reg;
        logic [2:0]    reg_idx;
        logic [XW-1:0] value;
    } opnd_s;

    typedef struct packed {
        logic [AW-1:0] base;
        logic [7:0]    disp;
        logic          use_idx;
        logic          idx_sel;
    } ind_s;

    typedef struct packed {
        logic      valid;
        op_e       op;
        src_mode_e src_mode;
        opnd_s     a;
        opnd_s     b;
        opnd_s     c;
        opnd_s     d;
        logic [4:0] dst1;
        logic [4:0] dst2;
        logic [2:0] store_reg;
        ind_s      src_ind;
        ind_s      st_ind;
        logic      src3_ext;
        logic      src4_ext;
    } req_s;

    typedef struct packed {
        logic          valid;
        logic [4:0]    idx;
        logic [XW-1:0] data;
    } wr_s;

    typedef struct packed {
        logic          valid;
        logic [AW-1:0] addr;
        logic [XW-1:0] data;
    } st_s;

endpackage : negate_alu_pkg

//--- negate_alu.sv
/*
 * Execute-stage datapath for multiply-with-subtract, negate-with-borrow, floating negate
 * and floating negate-with-store, with the condition flags and eight extended registers.
 * Assumes the decoder has already fetched memory operands into the request, and that
 * requests and index registers come from logic on the same clock.
 */
`timescale 1ns/1ps
module negate_alu #(
    parameter int EXT_REGS       = 8,
    parameter bit ACCEPT_CPU_SRC = 1'b1
) (
    // Clock and reset.
    input  wire logic                          sys_clk_i,
    input  wire logic                          arst_n_i,
    // Issue from the decoder.
    input  wire negate_alu_pkg::req_s          req_i,
    input  wire logic [negate_alu_pkg::AW-1:0] index_reg_zero_i,
    input  wire logic [negate_alu_pkg::AW-1:0] index_reg_one_i,
    // Register port.
    input  wire logic [negate_alu_pkg::BW-1:0] bus_addr_i,
    input  wire logic [negate_alu_pkg::DW-1:0] bus_wdata_i,
    input  wire logic                          bus_wr_i,
    input  wire logic                          bus_rd_i,
    output logic      [negate_alu_pkg::DW-1:0] bus_rdata_o,
    // Results.
    output negate_alu_pkg::wr_s                wr_a_o,
    output negate_alu_pkg::wr_s                wr_b_o,
    output negate_alu_pkg::st_s                st_o,
    output logic  [negate_alu_pkg::FLAG_W-1:0] flags_o,
    output logic                               busy_o,
    output logic                               done_o,
    output logic                               illegal_o
);
    if (EXT_REGS != negate_alu_pkg::NXR) begin : g_bad_regs
        $error("EXT_REGS must equal the extended register count");
    end

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_WAIT = 1'b1
    } state_e;

    state_e                              state_r;
    logic [negate_alu_pkg::XW-1:0]       xr_r [negate_alu_pkg::NXR];
    logic [negate_alu_pkg::FLAG_W-1:0]   flags_r;
    logic                                ovm_r;
    negate_alu_pkg::wr_s                 p_wra_r, p_wrb_r, c_wra, c_wrb, k_wra, k_wrb;
    negate_alu_pkg::st_s                 p_st_r, c_st, k_st;
    logic [negate_alu_pkg::FLAG_W-1:0]   p_fl_r, c_fl, k_fl;
    logic                                p_fu_r, c_fu, k_fu;
    logic                                issue, ill, two, commit;
    logic [negate_alu_pkg::XW-1:0]       s_v, b_v, c_v, d_v;
    logic [31:0]                         nb_s, nb_raw, nb_res, m_res, s_res;
    logic [32:0]                         nb_diff, s_diff;
    logic                                nb_ovf, m_ovf, s_ovf;
    logic signed [47:0]                  prod;
    logic [7:0]                          f_exp;
    logic [31:0]                         f_man;
    logic [negate_alu_pkg::XW-1:0]       f_res;
    logic                                f_ovf, f_uf;

    // Register operands come from the array as it stood at issue.
    function automatic logic [negate_alu_pkg::XW-1:0] fetch(input negate_alu_pkg::opnd_s o);
        fetch = o.is_reg ? xr_r[o.reg_idx] : o.value;
    endfunction : fetch

    // Effective indirect address: base plus displacement or a selected index register.
    function automatic logic [negate_alu_pkg::AW-1:0] eff(input negate_alu_pkg::ind_s i,
                                                          input logic [negate_alu_pkg::AW-1:0] x0,
                                                          input logic [negate_alu_pkg::AW-1:0] x1);
        logic [negate_alu_pkg::AW-1:0] ofs;
        ofs = i.use_idx ? (i.idx_sel ? x1 : x0) : {16'h0000, i.disp};
        eff = i.base + ofs;
    endfunction : eff

    // Operand fetch at the start of the execute cycle.
    always_comb begin
        s_v = fetch(req_i.a);
        b_v = fetch(req_i.b);
        c_v = fetch(req_i.c);
        d_v = fetch(req_i.d);
    end

    // Negate with borrow, signed, with optional saturation.
    always_comb begin
        nb_s    = (req_i.src_mode == negate_alu_pkg::MODE_IMM) ?
                  {{16{s_v[15]}}, s_v[15:0]} : s_v[31:0];
        nb_diff = 33'h0_0000_0000 - {1'b0, nb_s} - {32'h0000_0000, flags_r[negate_alu_pkg::FLAG_CARRY]};
        nb_raw  = nb_diff[31:0];
        nb_ovf  = nb_s[31] & nb_raw[31];
        nb_res  = (nb_ovf & ovm_r) ? negate_alu_pkg::INT_MAX : nb_raw;
    end

    // Signed 24x24 multiply and 32-bit subtract of the parallel pair.
    always_comb begin
        prod   = $signed(s_v[negate_alu_pkg::MUL_W-1:0]) * $signed(b_v[negate_alu_pkg::MUL_W-1:0]);
        m_ovf  = prod[47:32] != {16{prod[31]}};
        m_res  = (m_ovf & ovm_r) ? (prod[47] ? negate_alu_pkg::INT_MIN : negate_alu_pkg::INT_MAX)
                                 : prod[31:0];
        s_diff = {d_v[31], d_v[31:0]} - {c_v[31], c_v[31:0]};
        s_ovf  = s_diff[32] != s_diff[31];
        s_res  = (s_ovf & ovm_r) ? (s_diff[32] ? negate_alu_pkg::INT_MIN : negate_alu_pkg::INT_MAX)
                                 : s_diff[31:0];
    end

    // Floating negate of an exponent and sign-mantissa pair.
    always_comb begin
        f_exp = s_v[39:32];
        f_man = s_v[31:0];
        f_ovf = 1'b0;
        f_uf  = 1'b0;
        if (f_exp == negate_alu_pkg::EXP_ZERO) begin
            f_res = {negate_alu_pkg::EXP_ZERO, 32'h0000_0000};
        end else if (f_man == negate_alu_pkg::MANT_NEG_TWO) begin
            f_ovf = f_exp == negate_alu_pkg::EXP_MAX;
            f_res = {f_exp + 8'h01, 32'h0000_0000};
            if (f_ovf & ovm_r) begin
                f_res = {negate_alu_pkg::EXP_MAX, negate_alu_pkg::INT_MAX};
            end
        end else if (f_man == 32'h0000_0000) begin
            f_uf  = f_exp == negate_alu_pkg::EXP_MIN;
            f_res = f_uf ? {negate_alu_pkg::EXP_ZERO, 32'h0000_0000}
                         : {f_exp - 8'h01, negate_alu_pkg::MANT_NEG_TWO};
        end else begin
            f_res = {f_exp, 32'h0000_0000 - f_man};
        end
    end

    // Legality, cycle count and the results this issue would commit.
    always_comb begin
        ill   = 1'b0;
        c_wra = '0;
        c_wrb = '0;
        c_st  = '0;
        c_fl  = flags_r;
        c_fu  = 1'b0;
        two   = 1'b0;
        case (req_i.op)
            negate_alu_pkg::OP_MPY_SUB: begin
                ill   = (req_i.dst1 >= negate_alu_pkg::EXT_LIMIT) | (req_i.dst2 >= negate_alu_pkg::EXT_LIMIT);
                two   = req_i.src3_ext;
                c_wra = '{1'b1, req_i.dst1, {8'h00, m_res}};
                c_wrb = '{1'b1, req_i.dst2, {8'h00, s_res}};
                c_fu  = 1'b1;
                c_fl[negate_alu_pkg::FLAG_UNDERFLOW] = (m_ovf & prod[47]) | (s_ovf & s_diff[32]);
                c_fl[negate_alu_pkg::FLAG_NEGATIVE]  = 1'b0;
                c_fl[negate_alu_pkg::FLAG_ZERO]      = 1'b0;
                c_fl[negate_alu_pkg::FLAG_OVERFLOW]  = m_ovf | s_ovf;
                c_fl[negate_alu_pkg::FLAG_LATCHED_OVERFLOW] = flags_r[negate_alu_pkg::FLAG_LATCHED_OVERFLOW]
                                                            | m_ovf | s_ovf;
            end
            negate_alu_pkg::OP_INT_NEGATE_WITH_BORROW: begin
                c_wra = '{1'b1, req_i.dst1, {8'h00, nb_res}};
                c_fu  = req_i.dst1 < negate_alu_pkg::EXT_LIMIT;
                c_fl[negate_alu_pkg::FLAG_CARRY]     = nb_diff[32];
                c_fl[negate_alu_pkg::FLAG_UNDERFLOW] = 1'b0;
                c_fl[negate_alu_pkg::FLAG_NEGATIVE]  = nb_res[31];
                c_fl[negate_alu_pkg::FLAG_ZERO]      = nb_res == 32'h0000_0000;
                c_fl[negate_alu_pkg::FLAG_OVERFLOW]  = nb_ovf;
                c_fl[negate_alu_pkg::FLAG_LATCHED_OVERFLOW] = flags_r[negate_alu_pkg::FLAG_LATCHED_OVERFLOW]
                                                            | nb_ovf;
            end
            default: begin
                // Both float forms share the negate and its flags.
                ill = req_i.dst1 >= negate_alu_pkg::EXT_LIMIT;
                if (req_i.op == negate_alu_pkg::OP_FLOAT_NEGATE_ST) begin
                    ill = ill | (!req_i.st_ind.use_idx & (req_i.st_ind.disp > negate_alu_pkg::PAR_DISP_MAX))
                              | ((req_i.src_mode == negate_alu_pkg::MODE_REG) ? !ACCEPT_CPU_SRC
                                 : (!req_i.src_ind.use_idx
                                    & (req_i.src_ind.disp > negate_alu_pkg::PAR_DISP_MAX)));
                    c_st = '{1'b1, eff(req_i.st_ind, index_reg_zero_i, index_reg_one_i),
                             xr_r[req_i.store_reg]};
                end
                c_wra = '{1'b1, req_i.dst1, f_res};
                c_fu  = 1'b1;
                c_fl[negate_alu_pkg::FLAG_UNDERFLOW] = f_uf;
                c_fl[negate_alu_pkg::FLAG_LATCHED_UNDERFLOW] = flags_r[negate_alu_pkg::FLAG_LATCHED_UNDERFLOW]
                                                             | f_uf;
                c_fl[negate_alu_pkg::FLAG_OVERFLOW]  = f_ovf;
                c_fl[negate_alu_pkg::FLAG_LATCHED_OVERFLOW] = flags_r[negate_alu_pkg::FLAG_LATCHED_OVERFLOW]
                                                            | f_ovf;
                c_fl[negate_alu_pkg::FLAG_NEGATIVE]  = f_res[31] & (f_res[39:32] != negate_alu_pkg::EXP_ZERO);
                c_fl[negate_alu_pkg::FLAG_ZERO]      = f_res[39:32] == negate_alu_pkg::EXP_ZERO;
            end
        endcase
    end

    // Commit selection: a waiting issue commits its held results.
    always_comb begin
        issue  = (state_r == ST_IDLE) & req_i.valid;
        commit = (issue & !ill & !two) | (state_r == ST_WAIT);
        k_wra  = (state_r == ST_WAIT) ? p_wra_r : c_wra;
        k_wrb  = (state_r == ST_WAIT) ? p_wrb_r : c_wrb;
        k_st   = (state_r == ST_WAIT) ? p_st_r  : c_st;
        k_fl   = (state_r == ST_WAIT) ? p_fl_r  : c_fl;
        k_fu   = (state_r == ST_WAIT) ? p_fu_r  : c_fu;
    end

    // Sequencer and held results for the two-cycle form.
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_r <= ST_IDLE;
            p_wra_r <= '0;
            p_wrb_r <= '0;
            p_st_r  <= '0;
            p_fl_r  <= negate_alu_pkg::FLAGS_RST;
            p_fu_r  <= 1'b0;
        end else if (state_r == ST_WAIT) begin
            state_r <= ST_IDLE;
        end else if (issue & !ill & two) begin
            state_r <= ST_WAIT;
            p_wra_r <= c_wra;
            p_wrb_r <= c_wrb;
            p_st_r  <= c_st;
            p_fl_r  <= c_fl;
            p_fu_r  <= c_fu;
        end
    end

    // Result ports, one-cycle pulses after the commit edge.
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_a_o    <= '0;
            wr_b_o    <= '0;
            st_o      <= '0;
            done_o    <= 1'b0;
            illegal_o <= 1'b0;
            busy_o    <= 1'b0;
        end else begin
            wr_a_o    <= commit ? k_wra : '0;
            wr_b_o    <= commit ? k_wrb : '0;
            st_o      <= commit ? k_st : '0;
            done_o    <= commit;
            illegal_o <= issue & ill;
            busy_o    <= issue & !ill & two;
        end
    end

    // Flags: hardware commit wins over a software write in the same cycle.
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            flags_r <= negate_alu_pkg::FLAGS_RST;
        end else if (commit & k_fu) begin
            flags_r <= k_fl;
        end else if (bus_wr_i & (bus_addr_i == negate_alu_pkg::OFS_FLAGS)) begin
            flags_r <= bus_wdata_i[negate_alu_pkg::FLAG_W-1:0];
        end
    end

    // Saturate-mode control bit.
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ovm_r <= negate_alu_pkg::CTRL_RST;
        end else if (bus_wr_i & (bus_addr_i == negate_alu_pkg::OFS_CTRL)) begin
            ovm_r <= bus_wdata_i[negate_alu_pkg::CTRL_OVERFLOW_SATURATE];
        end
    end

    // Extended registers: results land at the end of the cycle, ahead of software writes.
    for (genvar i = 0; i < negate_alu_pkg::NXR; i++) begin : g_xr
        localparam logic [4:0] IDX = 5'(i);
        always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
                xr_r[i] <= negate_alu_pkg::XREG_RST;
            end else if (commit & k_wra.valid & (k_wra.idx == IDX)) begin
                xr_r[i] <= k_wra.data;
            end else if (commit & k_wrb.valid & (k_wrb.idx == IDX)) begin
                xr_r[i] <= k_wrb.data;
            end else if (bus_wr_i & (bus_addr_i == negate_alu_pkg::OFS_XLO + 8'(4 * i))) begin
                xr_r[i][31:0] <= bus_wdata_i;
            end else if (bus_wr_i & (bus_addr_i == negate_alu_pkg::OFS_XHI + 8'(4 * i))) begin
                xr_r[i][39:32] <= bus_wdata_i[7:0];
            end
        end
    end

    // Read data stands only in the cycle after the read strobe.
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            bus_rdata_o <= 32'h0000_0000;
        end else if (!bus_rd_i) begin
            bus_rdata_o <= 32'h0000_0000;
        end else if (bus_addr_i == negate_alu_pkg::OFS_CTRL) begin
            bus_rdata_o <= {31'h0000_0000, ovm_r};
        end else if (bus_addr_i == negate_alu_pkg::OFS_FLAGS) begin
            bus_rdata_o <= {25'h000_0000, flags_r};
        end else if ((bus_addr_i[7:5] == 3'h1) & (bus_addr_i[1:0] == 2'h0)) begin
            bus_rdata_o <= xr_r[bus_addr_i[4:2]][31:0];
        end else if ((bus_addr_i[7:5] == 3'h2) & (bus_addr_i[1:0] == 2'h0)) begin
            bus_rdata_o <= {24'h00_0000, xr_r[bus_addr_i[4:2]][39:32]};
        end else begin
            bus_rdata_o <= 32'h0000_0000;
        end
    end

    assign flags_o = flags_r;

endmodule : negate_alu

//--- negate_alu_properties.sv
/* Concurrent checks on the negate execute datapath: issue timing, flag updates and refusals.
   Assumes it is bound to negate_alu and sees only that module's ports. */
`timescale 1ns/1ps
module negate_alu_properties #(
    parameter int EXT_REGS = 8
) (
    // Clock and reset.
    input wire logic                                 sys_clk_i,
    input wire logic                                 arst_n_i,
    // Issue and register port.
    input wire negate_alu_pkg::req_s                 req_i,
    input wire logic [negate_alu_pkg::BW-1:0]        bus_addr_i,
    input wire logic                                 bus_wr_i,
    // Results.
    input wire negate_alu_pkg::wr_s                  wr_a_o,
    input wire negate_alu_pkg::wr_s                  wr_b_o,
    input wire negate_alu_pkg::st_s                  st_o,
    input wire logic [negate_alu_pkg::FLAG_W-1:0]    flags_o,
    input wire logic                                 busy_o,
    input wire logic                                 done_o,
    input wire logic                                 illegal_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);

    // Accepted issues per operation and software writes to the flags.
    logic go, ngb, ngf, mpy, flw;
    assign go  = req_i.valid && !busy_o;
    assign ngb = go && req_i.op == negate_alu_pkg::OP_INT_NEGATE_WITH_BORROW;
    assign ngf = go && req_i.op == negate_alu_pkg::OP_FLOAT_NEGATE && req_i.dst1 < EXT_REGS;
    assign mpy = go && req_i.op == negate_alu_pkg::OP_MPY_SUB && req_i.dst1 < EXT_REGS && req_i.dst2 < EXT_REGS;
    assign flw = bus_wr_i && bus_addr_i == negate_alu_pkg::OFS_FLAGS;

    a_int_negate_with_borrow_one_cycle: assert property (ngb |=> done_o && wr_a_o.idx == $past(req_i.dst1))
        else $error("negate with borrow result missing one cycle after issue");
    a_mpy_inner: assert property (mpy && !req_i.src3_ext |=> done_o && wr_b_o.valid && !busy_o)
        else $error("internal multiply subtract not done in one cycle");
    a_mpy_outer: assert property (mpy && req_i.src3_ext |=> busy_o && !done_o ##1 done_o && wr_b_o.valid)
        else $error("external multiply subtract not done in two cycles");
    a_mpy_nz_low: assert property (wr_b_o.valid |-> !flags_o[negate_alu_pkg::FLAG_ZERO] && !flags_o[3])
        else $error("multiply subtract left negative or zero set");
    a_lv_sticky: assert property ($fell(flags_o[negate_alu_pkg::FLAG_LATCHED_OVERFLOW]) |-> $past(flw))
        else $error("latched overflow cleared without a flags write");
    a_int_negate_with_borrow_uf_keep: assert property (ngb && req_i.dst1 < EXT_REGS |=> !flags_o[4] && $stable(flags_o[6]))
        else $error("negate with borrow disturbed underflow flags");
    a_flags_untouched: assert property (ngb && req_i.dst1 >= EXT_REGS && !bus_wr_i |=> $stable(flags_o))
        else $error("flags changed for a non extended destination");
    a_float_negate_carry_kept: assert property (ngf |=> done_o && $stable(flags_o[0]))
        else $error("float negate changed carry or missed its cycle");
    a_refusal_silent: assert property (illegal_o |-> !wr_a_o.valid && !st_o.valid && !done_o)
        else $error("refused issue still wrote a result");

    // Main scenarios reached.
    c_store: cover property (go && req_i.op == negate_alu_pkg::OP_FLOAT_NEGATE_ST);
    c_busy: cover property (busy_o);
    c_refused: cover property (illegal_o);
endmodule : negate_alu_properties

bind negate_alu negate_alu_properties #(.EXT_REGS(EXT_REGS)) i_props (.sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i), .req_i(req_i), .bus_addr_i(bus_addr_i), .bus_wr_i(bus_wr_i), .wr_a_o(wr_a_o),
    .wr_b_o(wr_b_o), .st_o(st_o), .flags_o(flags_o), .busy_o(busy_o), .done_o(done_o), .illegal_o(illegal_o));

//--- negate_alu_tb.sv
/* Self-checking bench for the negate execute datapath.
   Assumes the design answers one cycle after issue, two for an external multiply operand. */
`timescale 1ns/1ps
module negate_alu_tb;
    logic                 clk = 1'b0;
    logic                 arst_n = 1'b0;
    negate_alu_pkg::req_s req = '0;
    logic [7:0]           baddr = '0;
    logic [31:0]          bwdata = '0;
    logic                 bwr = 1'b0;
    logic                 brd = 1'b0;
    logic [31:0]          rdata;
    negate_alu_pkg::wr_s  wr_a, wr_b;
    negate_alu_pkg::st_s  st;
    logic [6:0]           flags;
    logic                 busy, done, illegal;
    int                   failures = 0;
    int                   n_compared = 0;

    // Clock at 100 MHz.
    always #5 clk = ~clk;

    negate_alu i_dut (.sys_clk_i(clk), .arst_n_i(arst_n), .req_i(req), .index_reg_zero_i(24'h000004),
        .index_reg_one_i(24'h000008), .bus_addr_i(baddr), .bus_wdata_i(bwdata), .bus_wr_i(bwr),
        .bus_rd_i(brd), .bus_rdata_o(rdata), .wr_a_o(wr_a), .wr_b_o(wr_b), .st_o(st), .flags_o(flags),
        .busy_o(busy), .done_o(done), .illegal_o(illegal));

    // Compares one result and counts it.
    task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // One register write cycle.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        baddr <= a;
        bwdata <= d;
        bwr <= 1'b1;
        @(posedge clk);
        bwr <= 1'b0;
    endtask : wr

    // One register read cycle; data taken in the following cycle.
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        baddr <= a;
        brd <= 1'b1;
        @(posedge clk);
        brd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask : rd

    // Issues one request and returns once its results stand.
    task automatic iss(input negate_alu_pkg::req_s r, output logic two);
        @(posedge clk);
        req <= r;
        @(posedge clk);
        req.valid <= 1'b0;
        #1;
        two = (busy === 1'b1);
        if (two) begin
            @(posedge clk);
            #1;
        end
    endtask : iss

    // Builds a request with one source value.
    function automatic negate_alu_pkg::req_s mk(input negate_alu_pkg::op_e o, input logic [1:0] m,
                                                input logic [39:0] v, input logic [4:0] d);
        negate_alu_pkg::req_s r;
        r = '0;
        r.valid = 1'b1;
        r.op = o;
        r.src_mode = negate_alu_pkg::src_mode_e'(m);
        r.a.value = v;
        r.dst1 = d;
        return r;
    endfunction : mk

    // Prints the counts and the verdict, then stops.
    task automatic complete_run;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run

    // Cuts a hang short.
    initial begin
        #200000;
        failures++;
        complete_run();
    end

    // Main sequence.
    initial begin
        logic [31:0] d;
        logic two;
        negate_alu_pkg::req_s r;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        rd(negate_alu_pkg::OFS_FLAGS, d);
        chk("flags after reset", 40'h0, d);
        rd(8'hfc, d);
        chk("unmapped read", 40'h0, d);
        wr(negate_alu_pkg::OFS_FLAGS, 32'h01);
        iss(mk(negate_alu_pkg::OP_INT_NEGATE_WITH_BORROW, 2'b00, 40'h00_ffff_ffcb, 5'd7), two);
        chk("int_negate_with_borrow result", 40'h00_0000_0034, wr_a.data);
        chk("int_negate_with_borrow flags", 40'h01, flags);
        rd(8'h3c, d);
        chk("reg 7 low", 40'h34, d);
        // Every source field, with underflow set so its clearing shows.
        for (int m = 0; m < 4; m++) begin
            wr(negate_alu_pkg::OFS_FLAGS, 32'h50);
            iss(mk(negate_alu_pkg::OP_INT_NEGATE_WITH_BORROW, m[1:0], 40'h1, 5'd3), two);
            chk("int_negate_with_borrow mode result", 40'h00_ffff_ffff, wr_a.data);
            chk("int_negate_with_borrow mode flags", 40'h49, flags);
        end
        wr(negate_alu_pkg::OFS_FLAGS, 32'h00);
        iss(mk(negate_alu_pkg::OP_INT_NEGATE_WITH_BORROW, 2'b11, 40'h0, 5'd3), two);
        chk("int_negate_with_borrow zero flags", 40'h04, flags);
        // Overflow without and with saturation.
        for (int s = 0; s < 2; s++) begin
            wr(negate_alu_pkg::OFS_CTRL, s);
            wr(negate_alu_pkg::OFS_FLAGS, 32'h00);
            iss(mk(negate_alu_pkg::OP_INT_NEGATE_WITH_BORROW, 2'b00, 40'h00_8000_0000, 5'd1), two);
            chk("int_negate_with_borrow ovf result", s ? 40'h00_7fff_ffff : 40'h00_8000_0000, wr_a.data);
            chk("int_negate_with_borrow ovf flags", s ? 40'h23 : 40'h2b, flags);
        end
        wr(negate_alu_pkg::OFS_CTRL, 32'h0);
        iss(mk(negate_alu_pkg::OP_INT_NEGATE_WITH_BORROW, 2'b00, 40'h1, 5'd1), two);
        chk("sticky flags", 40'h29, flags);
        iss(mk(negate_alu_pkg::OP_INT_NEGATE_WITH_BORROW, 2'b00, 40'h2, 5'h10), two);
        chk("cpu reg result", 40'h00_ffff_fffd, wr_a.data);
        chk("cpu reg flags", 40'h29, flags);
        wr(negate_alu_pkg::OFS_FLAGS, 32'h01);
        iss(mk(negate_alu_pkg::OP_FLOAT_NEGATE, 2'b01, 40'h07_0c80_0000, 5'd1), two);
        chk("float_negate result", 40'h07_f380_0000, wr_a.data);
        chk("float_negate flags", 40'h09, flags);
        // Multiply-subtract, internal then external with product overflow.
        r = mk(negate_alu_pkg::OP_MPY_SUB, 2'b00, 40'h3, 5'd0);
        r.b.value = 40'h5;
        r.c.value = 40'h4;
        r.d.value = 40'ha;
        r.dst2 = 5'd2;
        iss(r, two);
        chk("mpy cycles", 40'h0, two);
        chk("mpy product", 40'hf, wr_a.data);
        chk("mpy diff", 40'h6, wr_b.data);
        chk("mpy flags", 40'h01, flags);
        r.src3_ext = 1'b1;
        r.a.value = 40'h1_0000;
        r.b.value = 40'h1_0000;
        iss(r, two);
        chk("ext cycles", 40'h1, two);
        chk("ext flags", 40'h23, flags);
        // Negate with store reads the stored register before the negate writes it.
        wr(8'h28, 32'h19);
        wr(negate_alu_pkg::OFS_FLAGS, 32'h00);
        r = mk(negate_alu_pkg::OP_FLOAT_NEGATE_ST, 2'b10, 40'h07_0c80_0000, 5'd2);
        r.store_reg = 3'd2;
        r.st_ind.disp = 8'h01;
        r.src_ind.disp = 8'h01;
        iss(r, two);
        chk("store valid", 40'h1, st.valid);
        chk("store data", 40'h19, st.data);
        chk("store addr", 40'h1, st.addr);
        rd(8'h28, d);
        chk("reg 2 low", 40'hf380_0000, d);
        r.st_ind.disp = 8'h02;
        iss(r, two);
        chk("refused", 40'h1, illegal);
        chk("refused write", 40'h0, wr_a.valid);
        r.st_ind.use_idx = 1'b1;
        r.src_mode = negate_alu_pkg::MODE_REG;
        iss(r, two);
        chk("index store", 40'h1, st.valid);
        chk("index store addr", 40'h4, st.addr);
        // Float underflow, then float overflow wrapping to zero.
        wr(negate_alu_pkg::OFS_FLAGS, 32'h01);
        iss(mk(negate_alu_pkg::OP_FLOAT_NEGATE, 2'b11, 40'h81_0000_0000, 5'd4), two);
        chk("float_negate underflow result", 40'h80_0000_0000, wr_a.data);
        chk("float_negate underflow flags", 40'h55, flags);
        iss(mk(negate_alu_pkg::OP_FLOAT_NEGATE, 2'b00, 40'h7f_8000_0000, 5'd4), two);
        chk("float_negate overflow flags", 40'h67, flags);
        complete_run();
    end
endmodule : negate_alu_tb
